/* src/instr_state_endian_lanes.sv */
// Instruction-state control, compact-set load/store/stack decode and
// data bus byte-lane mapping for a 32-bit core.
// Assumes the register file, mode logic and memory system sit outside and
// that all inputs are synchronous to i_sys_clk.
//
// Notes on behaviour
// - Wide state fetches word-aligned 32-bit instructions.
// - Compact state fetches halfword-aligned 16-bit instructions.
// - In compact state program counter bit 1 picks the halfword.
// - Switching state touches neither mode nor register contents.
// - Branch-exchange with operand bit 0 set enters compact state.
// - Branch-exchange with operand bit 0 clear enters wide state.
// - Exception return restores compact state if entered from it.
// - Any exception enters wide state, saves counter to link, jumps to vector.
// - Memory is bytes upward from zero, four per word.
// - Byte order follows the control register big-endian bit.
// - Big-endian: byte 0 on bits 31..24, word named by top byte.
// - Little-endian: byte 0 on bits 7..0.
// - Immediate offsets: seven bits word, six halfword, five byte.
// - Counter- or stack-relative word loads take a ten-bit offset.
// - Address generation adds ten-bit offset to stack or counter.
// - Push may add link register; pop may load counter and branch.
// - Compact branch-exchange takes target from low or high register.
// - Compact state: counter bit 0 reads zero.
// - Wide state: counter bits 1..0 read zero.
`timescale 1ns/1ps
module instr_state_endian_lanes
  import isl_pkg::*;
#(
  parameter logic [31:0] VECTOR_BASE = RESET_VECTOR_BASE
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // System control
  input wire logic i_big_endian,
  // Instruction fetch
  input wire logic i_fetch_advance,
  input wire logic [31:0] i_fetch_word,
  output logic [31:0] o_fetch_addr,
  output logic [31:0] o_instr,
  output logic [31:0] o_pc,
  output logic o_state_compact,
  // Branch-exchange
  input wire logic i_bx_valid,
  input wire logic [31:0] i_bx_operand,
  // Exception entry and return
  input wire logic i_exc_valid,
  input wire logic [2:0] i_exc_kind,
  input wire logic i_ret_valid,
  input wire logic [2:0] i_ret_mode,
  input wire logic [31:0] i_ret_addr,
  output logic o_link_we,
  output logic [2:0] o_link_mode,
  output logic [31:0] o_link_value,
  // Compact-set decode
  output logic [3:0] o_dec_kind,
  output logic o_dec_load,
  output logic [1:0] o_dec_size,
  output logic [2:0] o_dec_rd,
  output logic [3:0] o_dec_base,
  output logic [9:0] o_dec_offset,
  output logic [7:0] o_dec_reglist,
  output logic o_dec_extra_reg,
  output logic [3:0] o_bx_reg_index,
  // Data access request
  input wire logic i_mem_req,
  input wire logic i_mem_write,
  input wire logic [1:0] i_mem_size,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_store_data,
  input wire logic i_mem_rdata_valid,
  input wire logic [31:0] i_mem_rdata,
  // Data bus towards memory
  output logic o_bus_req,
  output logic o_bus_write,
  output logic [31:0] o_bus_addr,
  output logic [3:0] o_bus_lanes,
  output logic [31:0] o_bus_wdata,
  output logic [31:0] o_load_data
);

  // ----------------------------------------------------------------
  // Lane mapper instances
  // ----------------------------------------------------------------
  lane_if data_lp ();
  lane_if fetch_lp ();

  byte_lane_map data_map (
    .lp(data_lp.mapper)
  );
  byte_lane_map fetch_map (
    .lp(fetch_lp.mapper)
  );

  // ----------------------------------------------------------------
  // Instruction state and program counter
  // ----------------------------------------------------------------
  isa_state_t state_reg, state_next;
  logic [31:0] pc_reg, pc_next;
  logic [NUM_EXC_MODES-1:0] saved_reg, saved_next;
  logic link_we_reg, link_we_next;
  logic [2:0] link_mode_reg, link_mode_next;
  logic [31:0] link_value_reg, link_value_next;
  exc_mode_t exc_mode;
  logic [31:0] pc_raw;

  // Exception kind to the mode it enters
  always_comb begin
    unique case (exc_kind_t'(i_exc_kind))
      EX_RESET, EX_TRAP: exc_mode = MD_SVC;
      EX_UNDEFINED_INSTRUCTION_TRAP: exc_mode = MD_UND;
      EX_PABT, EX_DABT: exc_mode = MD_ABT;
      EX_IRQ: exc_mode = MD_IRQ;
      EX_FIQ: exc_mode = MD_FIQ;
      default: exc_mode = MD_UND;
    endcase
  end

  // Next state: exception beats return beats branch-exchange beats advance
  always_comb begin
    state_next = state_reg;
    pc_raw = pc_reg;
    saved_next = saved_reg;
    link_we_next = 1'b0;
    link_mode_next = link_mode_reg;
    link_value_next = link_value_reg;
    if (i_exc_valid) begin
      state_next = ST_WIDE;
      pc_raw = VECTOR_BASE + {27'h000_0000, i_exc_kind, 2'h0};
      link_we_next = 1'b1;
      link_mode_next = exc_mode;
      link_value_next = pc_reg;
      saved_next[exc_mode] = (state_reg == ST_COMPACT);
    end else if (i_ret_valid) begin
      state_next = (i_ret_mode < 3'(NUM_EXC_MODES)) && saved_reg[i_ret_mode] ?
                   ST_COMPACT : ST_WIDE;
      pc_raw = i_ret_addr;
    end else if (i_bx_valid) begin
      // operand bit 0 picks the state
      state_next = i_bx_operand[0] ? ST_COMPACT : ST_WIDE;
      pc_raw = i_bx_operand;
    end else if (i_fetch_advance) begin
      pc_raw = pc_reg + ((state_reg == ST_COMPACT) ? COMPACT_STEP : WIDE_STEP);
    end
    // clear the low counter bits for the new state
    pc_next = pc_raw & ((state_next == ST_COMPACT) ? COMPACT_PC_MASK : WIDE_PC_MASK);
  end

  // Reset is itself an exception: wide state, counter at the reset vector.
  // only state, counter, saved-state flags and the link request move here; modes and registers stay outside.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_WIDE;
      pc_reg <= VECTOR_BASE;
      saved_reg <= '0;
      link_we_reg <= 1'b0;
      link_mode_reg <= MD_SVC;
      link_value_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      saved_reg <= saved_next;
      link_we_reg <= link_we_next;
      link_mode_reg <= link_mode_next;
      link_value_reg <= link_value_next;
    end
  end

  assign o_pc = pc_reg;
  assign o_state_compact = (state_reg == ST_COMPACT);
  assign o_link_we = link_we_reg;
  assign o_link_mode = link_mode_reg;
  assign o_link_value = link_value_reg;

  // ----------------------------------------------------------------
  // Fetch path
  // ----------------------------------------------------------------
  logic [31:0] fetch_addr_reg, fetch_addr_next;
  logic [31:0] instr_reg, instr_next;

  // counter bit 1 picks the halfword through the lane mapper
  assign fetch_lp.addr_low = {pc_next[1], 1'b0};
  assign fetch_lp.size = SZ_HALF;
  assign fetch_lp.big_endian = i_big_endian;
  assign fetch_lp.store_data = 32'h0000_0000;
  assign fetch_lp.bus_word = i_fetch_word;

  // Instruction register follows the word returned for the next counter
  always_comb begin
    fetch_addr_next = {pc_next[31:2], 2'h0};
    if (state_next == ST_COMPACT) begin
      // one halfword of the fetched word
      instr_next = fetch_lp.load_data;
    end else begin
      instr_next = i_fetch_word;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fetch_addr_reg <= VECTOR_BASE;
      instr_reg <= 32'h0000_0000;
    end else begin
      fetch_addr_reg <= fetch_addr_next;
      instr_reg <= instr_next;
    end
  end

  assign o_fetch_addr = fetch_addr_reg;
  assign o_instr = instr_reg;

  // ----------------------------------------------------------------
  // Compact-set decode of load, store, stack and branch-exchange forms
  // ----------------------------------------------------------------
  dec_kind_t kind_next;
  logic load_next;
  acc_size_t size_next;
  logic [2:0] rd_next;
  logic [3:0] base_next;
  logic [9:0] offset_next;
  logic [7:0] reglist_next;
  logic extra_next;
  logic [3:0] bx_idx_next;
  logic [15:0] ci;
  logic [4:0] off5;
  logic [7:0] word8;

  assign ci = instr_next[15:0];
  assign off5 = ci[OFF5_LSB +: 5];
  assign word8 = ci[7:0];

  // Decodes the instruction about to be registered so fields align with it
  always_comb begin
    kind_next = DK_NONE;
    load_next = ci[LOAD_BIT];
    size_next = SZ_WORD;
    rd_next = ci[RD_LSB +: 3];
    base_next = {1'b0, ci[RB_LSB +: 3]};
    offset_next = 10'h000;
    reglist_next = 8'h00;
    extra_next = 1'b0;
    bx_idx_next = 4'h0;
    if (state_next == ST_COMPACT) begin
      if (ci[15:13] == 3'h3) begin
        // word offset scaled to 7 bits, byte offset 5 bits
        kind_next = DK_LS_IMM;
        size_next = ci[BYTE_BIT] ? SZ_BYTE : SZ_WORD;
        offset_next = ci[BYTE_BIT] ? {5'h00, off5} : {3'h0, off5, 2'h0};
      end else if (ci[15:12] == 4'h8) begin
        // halfword offset scaled to 6 bits
        kind_next = DK_LS_HALF;
        size_next = SZ_HALF;
        offset_next = {4'h0, off5, 1'b0};
      end else if (ci[15:11] == 5'h09) begin
        kind_next = DK_LOAD_PC;
        load_next = 1'b1;
        rd_next = ci[RD8_LSB +: 3];
        base_next = PC_INDEX;
        offset_next = {word8, 2'h0};
      end else if (ci[15:12] == 4'h9) begin
        kind_next = DK_LS_SP;
        rd_next = ci[RD8_LSB +: 3];
        base_next = SP_INDEX;
        offset_next = {word8, 2'h0};
      end else if (ci[15:12] == 4'ha) begin
        // stack or counter plus offset into a low register
        kind_next = DK_ADDR_GEN;
        load_next = 1'b0;
        rd_next = ci[RD8_LSB +: 3];
        base_next = ci[LOAD_BIT] ? SP_INDEX : PC_INDEX;
        offset_next = {word8, 2'h0};
      end else if (ci[15:12] == 4'hb && ci[10:9] == 2'h2) begin
        // push with link register, pop into the counter
        kind_next = ci[LOAD_BIT] ? DK_POP : DK_PUSH;
        base_next = SP_INDEX;
        reglist_next = word8;
        extra_next = ci[EXTRA_REG_BIT];
      end else if (ci[15:8] == 8'h47) begin
        // target from a low or a high register
        kind_next = DK_BX;
        load_next = 1'b0;
        bx_idx_next = {ci[HI_SRC_BIT], ci[RB_LSB +: 3]};
      end
    end
  end

  logic [3:0] kind_reg;
  logic load_reg;
  logic [1:0] size_reg;
  logic [2:0] rd_reg;
  logic [3:0] base_reg;
  logic [9:0] offset_reg;
  logic [7:0] reglist_reg;
  logic extra_reg;
  logic [3:0] bx_idx_reg;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      kind_reg <= DK_NONE;
      load_reg <= 1'b0;
      size_reg <= SZ_WORD;
      rd_reg <= 3'h0;
      base_reg <= 4'h0;
      offset_reg <= 10'h000;
      reglist_reg <= 8'h00;
      extra_reg <= 1'b0;
      bx_idx_reg <= 4'h0;
    end else begin
      kind_reg <= kind_next;
      load_reg <= load_next;
      size_reg <= size_next;
      rd_reg <= rd_next;
      base_reg <= base_next;
      offset_reg <= offset_next;
      reglist_reg <= reglist_next;
      extra_reg <= extra_next;
      bx_idx_reg <= bx_idx_next;
    end
  end

  assign o_dec_kind = kind_reg;
  assign o_dec_load = load_reg;
  assign o_dec_size = size_reg;
  assign o_dec_rd = rd_reg;
  assign o_dec_base = base_reg;
  assign o_dec_offset = offset_reg;
  assign o_dec_reglist = reglist_reg;
  assign o_dec_extra_reg = extra_reg;
  assign o_bx_reg_index = bx_idx_reg;

  // ----------------------------------------------------------------
  // Data bus lanes
  // ----------------------------------------------------------------
  logic bus_req_reg, bus_req_next;
  logic bus_write_reg, bus_write_next;
  logic [31:0] bus_addr_reg, bus_addr_next;
  logic [3:0] bus_lanes_reg, bus_lanes_next;
  logic [31:0] bus_wdata_reg, bus_wdata_next;
  logic [31:0] load_data_reg, load_data_next;
  acc_size_t load_size_reg, load_size_next;
  logic [1:0] load_low_reg, load_low_next;

  // control-register endian bit steers both mappers
  assign data_lp.big_endian = i_big_endian;
  assign data_lp.addr_low = i_mem_req ? i_mem_addr[1:0] : load_low_reg;
  assign data_lp.size = i_mem_req ? acc_size_t'(i_mem_size) : load_size_reg;
  assign data_lp.store_data = i_store_data;
  assign data_lp.bus_word = i_mem_rdata;

  // Request registered one cycle; the access's size and offset are kept
  // so the returned word can be unpacked later.
  always_comb begin
    bus_req_next = i_mem_req;
    bus_write_next = i_mem_req & i_mem_write;
    bus_addr_next = i_mem_req ? {i_mem_addr[31:2], 2'h0} : bus_addr_reg;
    // active lanes from access size, byte order and low address bits
    bus_lanes_next = i_mem_req ? data_lp.lanes : 4'h0;
    bus_wdata_next = i_mem_req ? data_lp.lane_data : bus_wdata_reg;
    load_size_next = i_mem_req ? acc_size_t'(i_mem_size) : load_size_reg;
    load_low_next = i_mem_req ? i_mem_addr[1:0] : load_low_reg;
    load_data_next = i_mem_rdata_valid ? data_lp.load_data : load_data_reg;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_req_reg <= 1'b0;
      bus_write_reg <= 1'b0;
      bus_addr_reg <= 32'h0000_0000;
      bus_lanes_reg <= 4'h0;
      bus_wdata_reg <= 32'h0000_0000;
      load_data_reg <= 32'h0000_0000;
      load_size_reg <= SZ_WORD;
      load_low_reg <= 2'h0;
    end else begin
      bus_req_reg <= bus_req_next;
      bus_write_reg <= bus_write_next;
      bus_addr_reg <= bus_addr_next;
      bus_lanes_reg <= bus_lanes_next;
      bus_wdata_reg <= bus_wdata_next;
      load_data_reg <= load_data_next;
      load_size_reg <= load_size_next;
      load_low_reg <= load_low_next;
    end
  end

  assign o_bus_req = bus_req_reg;
  assign o_bus_write = bus_write_reg;
  assign o_bus_addr = bus_addr_reg;
  assign o_bus_lanes = bus_lanes_reg;
  assign o_bus_wdata = bus_wdata_reg;
  assign o_load_data = load_data_reg;

endmodule

/* src/isl_pkg.sv */
// Shared types and constants for the instruction-state and byte-lane block.
// Assumes a 32-bit core data bus and a single core clock domain.
package isl_pkg;

  // ----------------------------------------------------------------
  // Instruction state and access sizes
  // ----------------------------------------------------------------
  typedef enum logic {ST_WIDE = 1'b0, ST_COMPACT = 1'b1} isa_state_t;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} acc_size_t;

  // ----------------------------------------------------------------
  // Exceptions and the modes they enter
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EX_RESET = 3'h0, EX_UNDEFINED_INSTRUCTION_TRAP = 3'h1, EX_TRAP = 3'h2, EX_PABT = 3'h3,
    EX_DABT = 3'h4, EX_IRQ = 3'h6, EX_FIQ = 3'h7
  } exc_kind_t;
  typedef enum logic [2:0] {
    MD_SVC = 3'h0, MD_UND = 3'h1, MD_ABT = 3'h2, MD_IRQ = 3'h3, MD_FIQ = 3'h4
  } exc_mode_t;
  localparam int NUM_EXC_MODES = 5;

  // ----------------------------------------------------------------
  // Compact-set decode classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DK_NONE = 4'h0, DK_LS_IMM = 4'h1, DK_LS_HALF = 4'h2, DK_LOAD_PC = 4'h3,
    DK_LS_SP = 4'h4, DK_ADDR_GEN = 4'h5, DK_PUSH = 4'h6, DK_POP = 4'h7,
    DK_BX = 4'h8
  } dec_kind_t;

  // ----------------------------------------------------------------
  // Counts, steps and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] WIDE_STEP = 32'h0000_0004;
  localparam logic [31:0] COMPACT_STEP = 32'h0000_0002;
  localparam logic [31:0] WIDE_PC_MASK = 32'hffff_fffc;
  localparam logic [31:0] COMPACT_PC_MASK = 32'hffff_fffe;
  localparam logic [31:0] RESET_VECTOR_BASE = 32'h0000_0000;
  localparam logic [3:0] SP_INDEX = 4'hd;
  localparam logic [3:0] PC_INDEX = 4'hf;
  localparam logic [3:0] LANES_ALL = 4'hf;
  localparam logic [3:0] LANES_LOW_HALF = 4'h3;
  localparam logic [3:0] LANES_HIGH_HALF = 4'hc;
  localparam logic [1:0] LAST_LANE = 2'h3;

  // ----------------------------------------------------------------
  // Compact instruction field positions
  // ----------------------------------------------------------------
  localparam int OFF5_LSB = 6;
  localparam int RB_LSB = 3;
  localparam int RD_LSB = 0;
  localparam int RD8_LSB = 8;
  localparam int LOAD_BIT = 11;
  localparam int BYTE_BIT = 12;
  localparam int EXTRA_REG_BIT = 8;
  localparam int HI_SRC_BIT = 6;

endpackage

/* src/lane_if.sv */
// Carrier between the core logic and the byte-lane mapper.
// Assumes both ends sit in the same clock domain; all signals are combinational.
`timescale 1ns/1ps
interface lane_if;
  import isl_pkg::*;
  logic [1:0] addr_low;
  acc_size_t size;
  logic big_endian;
  logic [31:0] store_data;
  logic [31:0] bus_word;
  logic [3:0] lanes;
  logic [31:0] lane_data;
  logic [31:0] load_data;

  modport core (output addr_low, size, big_endian, store_data, bus_word,
                input lanes, lane_data, load_data);
  modport mapper (input addr_low, size, big_endian, store_data, bus_word,
                  output lanes, lane_data, load_data);
endinterface

/* src/byte_lane_map.sv */
// Byte-lane mapper: picks active data bus lanes, replicates store data onto them and
// shifts load data from them under big- or little-endian ordering.
// Assumes aligned halfword and word addresses; purely combinational.
`timescale 1ns/1ps
module byte_lane_map
  import isl_pkg::*;
(
  lane_if.mapper lp
);

  logic [1:0] low_lane;
  logic [4:0] shift_bits;

  // ----------------------------------------------------------------
  // Lane selection
  // ----------------------------------------------------------------
  // endian lane choice
  always_comb begin
    low_lane = 2'h0;
    lp.lanes = LANES_ALL;
    unique case (lp.size)
      SZ_BYTE: begin
        // Big-endian puts byte 0 on the top lane, little-endian on the bottom
        low_lane = lp.big_endian ? (LAST_LANE - lp.addr_low) : lp.addr_low;
        lp.lanes = 4'(4'h1 << low_lane);
      end
      SZ_HALF: begin
        low_lane = (lp.addr_low[1] ^ lp.big_endian) ? 2'h2 : 2'h0;
        lp.lanes = low_lane[1] ? LANES_HIGH_HALF : LANES_LOW_HALF;
      end
      default: begin
        // Words and any unused size code take the full bus
        low_lane = 2'h0;
        lp.lanes = LANES_ALL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Data steering
  // ----------------------------------------------------------------
  assign shift_bits = {low_lane, 3'h0};

  // Stores replicate the item on every lane so any lane choice is covered
  always_comb begin
    unique case (lp.size)
      SZ_BYTE: lp.lane_data = {4{lp.store_data[7:0]}};
      SZ_HALF: lp.lane_data = {2{lp.store_data[15:0]}};
      default: lp.lane_data = lp.store_data;
    endcase
  end

  // Loads come back right-aligned and zero-extended
  always_comb begin
    unique case (lp.size)
      SZ_BYTE: lp.load_data = {24'h00_0000, 8'(lp.bus_word >> shift_bits)};
      SZ_HALF: lp.load_data = {16'h0000, 16'(lp.bus_word >> shift_bits)};
      default: lp.load_data = lp.bus_word;
    endcase
  end

endmodule

/* verification/isl_monitor.sv */
// Port checker for the instruction-state and byte-lane block.
// Assumes a bind onto the top module and one clock domain.
`timescale 1ns/1ps
module isl_monitor
  import isl_pkg::*;
#(
  parameter logic [31:0] VECTOR_BASE = RESET_VECTOR_BASE
) (
  // Clock, reset and inputs
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_big_endian,
  input wire logic i_fetch_advance,
  input wire logic i_bx_valid,
  input wire logic [31:0] i_bx_operand,
  input wire logic i_exc_valid,
  input wire logic [2:0] i_exc_kind,
  input wire logic i_ret_valid,
  input wire logic i_mem_req,
  input wire logic [1:0] i_mem_size,
  input wire logic [31:0] i_mem_addr,
  // Watched outputs
  input wire logic [31:0] o_pc,
  input wire logic o_state_compact,
  input wire logic [31:0] o_fetch_addr,
  input wire logic o_link_we,
  input wire logic [31:0] o_link_value,
  input wire logic [3:0] o_bus_lanes,
  input wire logic [3:0] o_dec_kind
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ----
  // Assertions
  // ----
  chk_bx_state: assert property (
    i_bx_valid && !i_exc_valid && !i_ret_valid |=> o_state_compact == $past(i_bx_operand[0]))
    else $error("wrong state after exchange");
  chk_exc_entry: assert property (
    i_exc_valid |=> !o_state_compact && o_link_we && o_link_value == $past(o_pc)
      && o_pc == VECTOR_BASE + {$past(i_exc_kind), 2'b00})
    else $error("exception entry wrong");
  chk_link_cause: assert property (o_link_we |-> $past(i_exc_valid))
    else $error("stray link write");
  chk_pc_half: assert property (o_state_compact |-> o_pc[0] == 1'b0)
    else $error("compact counter bit 0 set");
  chk_pc_word: assert property (!o_state_compact |-> o_pc[1:0] == 2'h0)
    else $error("wide counter low bits set");
  chk_fetch_word: assert property (o_fetch_addr == {o_pc[31:2], 2'h0})
    else $error("fetch address off counter");
  chk_step_size: assert property (
    i_fetch_advance && !i_exc_valid && !i_ret_valid && !i_bx_valid |=>
      o_pc == $past(o_pc) + ($past(o_state_compact) ? COMPACT_STEP : WIDE_STEP))
    else $error("counter step wrong");
  chk_byte_lane: assert property (
    i_mem_req && i_mem_size == 2'h0 |=> o_bus_lanes == ($past(i_big_endian) ?
      4'h8 >> $past(i_mem_addr[1:0]) : 4'h1 << $past(i_mem_addr[1:0])))
    else $error("byte lane wrong");
  chk_word_lanes: assert property (i_mem_req && i_mem_size == 2'h2 |=> o_bus_lanes == 4'hf)
    else $error("word lanes wrong");
  chk_wide_nodec: assert property (!o_state_compact |-> o_dec_kind == 4'h0)
    else $error("decode active in wide state");
  // Main scenarios reached
  cov_bx: cover property (i_bx_valid && i_bx_operand[0]);
  cov_exc: cover property (o_state_compact && i_exc_valid);
  cov_be_byte: cover property (i_mem_req && i_big_endian && i_mem_size == 2'h0);
endmodule

bind instr_state_endian_lanes isl_monitor #(.VECTOR_BASE(VECTOR_BASE)) u_mon (.*);

/* verification/mem_partner.sv */
// Memory model on the core data bus, answering reads with a fixed word.
// Assumes the bus request is a one-cycle pulse.
`timescale 1ns/1ps
module mem_partner #(
  parameter logic [31:0] DATA_WORD = 32'h4433_2211
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_slow,
  input wire logic i_bus_req,
  input wire logic i_bus_write,
  output logic o_rdata_valid,
  output logic [31:0] o_rdata
);
  logic [1:0] wait_reg;
  // Reads answer after one cycle, two when slow
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_reg <= 2'h0;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= (wait_reg == 2'h1);
      if (i_bus_req && !i_bus_write) wait_reg <= i_slow ? 2'h2 : 2'h1;
      else if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
    end
  end
  // lane n holds byte n
  // Inverted outside an answer so stale data cannot pass
  assign o_rdata = o_rdata_valid ? DATA_WORD : ~DATA_WORD;
endmodule

/* verification/instr_state_endian_lanes_tb.sv */
// Self-checking bench for the instruction-state and byte-lane block.
// Assumes the memory model answers loads; fetch word is fixed.
`timescale 1ns/1ps
module instr_state_endian_lanes_tb;
  import isl_pkg::*;
  localparam logic [31:0] FETCH_WORD = 32'h6fc1_b503;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_big_endian = 1'b0, i_fetch_advance = 1'b0, i_bx_valid = 1'b0, i_exc_valid = 1'b0;
  logic i_ret_valid = 1'b0, i_mem_req = 1'b0, i_mem_write = 1'b0, slow = 1'b0;
  logic [2:0] i_exc_kind = 3'h0, i_ret_mode = 3'h0;
  logic [1:0] i_mem_size = 2'h0;
  logic [31:0] i_bx_operand = 32'h0, i_ret_addr = 32'h0, i_mem_addr = 32'h0;
  logic [31:0] i_store_data = 32'h0, rdata, o_pc, o_instr, o_link_value, o_bus_wdata, o_load_data;
  logic rdata_valid, o_state_compact, o_link_we, o_bus_req, o_bus_write, o_dec_extra_reg;
  logic [2:0] o_link_mode;
  logic [3:0] o_bus_lanes, o_dec_kind;
  logic [1:0] o_dec_size;
  logic [9:0] o_dec_offset;
  logic [7:0] o_dec_reglist;
  int err_total = 0, check_count = 0;
  // Clock at 25 MHz
  always #20 i_sys_clk = ~i_sys_clk;
  instr_state_endian_lanes DUT (.i_sys_clk, .i_rstn, .i_big_endian, .i_fetch_advance,
    .i_fetch_word(FETCH_WORD), .o_fetch_addr(), .o_instr, .o_pc, .o_state_compact,
    .i_bx_valid, .i_bx_operand, .i_exc_valid, .i_exc_kind, .i_ret_valid, .i_ret_mode,
    .i_ret_addr, .o_link_we, .o_link_mode, .o_link_value, .o_dec_kind, .o_dec_load(),
    .o_dec_size, .o_dec_rd(), .o_dec_base(), .o_dec_offset, .o_dec_reglist, .o_dec_extra_reg,
    .o_bx_reg_index(), .i_mem_req, .i_mem_write, .i_mem_size, .i_mem_addr, .i_store_data,
    .i_mem_rdata_valid(rdata_valid), .i_mem_rdata(rdata), .o_bus_req, .o_bus_write,
    .o_bus_addr(), .o_bus_lanes, .o_bus_wdata, .o_load_data);
  mem_partner u_mem (.i_sys_clk, .i_rstn, .i_slow(slow), .i_bus_req(o_bus_req),
    .i_bus_write(o_bus_write), .o_rdata_valid(rdata_valid), .o_rdata(rdata));
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One-cycle event: 0 branch-exchange, 1 exception, 2 return, 3 advance, else none
  task automatic step(input int which, input logic [31:0] val, input logic [2:0] kind);
    @(posedge i_sys_clk);
    i_bx_operand <= val;
    i_ret_addr <= val;
    i_exc_kind <= kind;
    i_ret_mode <= kind;
    {i_bx_valid, i_exc_valid, i_ret_valid, i_fetch_advance} <= 4'h8 >> which;
    @(posedge i_sys_clk);
    {i_bx_valid, i_exc_valid, i_ret_valid, i_fetch_advance} <= 4'h0;
    #1;
  endtask
  // One-edge request; loads wait a bounded time
  task automatic mem_op(input logic wr, input acc_size_t sz, input logic [31:0] addr,
      input logic [31:0] dat, input logic [3:0] lanes, input logic [31:0] exp);
    @(posedge i_sys_clk);
    {i_mem_req, i_mem_write, i_mem_size, i_mem_addr, i_store_data} <= {1'b1, wr, sz, addr, dat};
    @(posedge i_sys_clk);
    i_mem_req <= 1'b0;
    #1;
    chk(o_bus_lanes, lanes);
    for (int n = 0; n < 8 && !wr && rdata_valid !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    @(posedge i_sys_clk);
    #1;
    chk(wr ? o_bus_wdata : o_load_data, exp);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_state();
    step(0, 32'h101, 3'h0);
    chk(o_state_compact, 1'b1);
    chk(o_pc, 32'h100);
    chk(o_instr, 32'hb503);
    chk(o_dec_kind, DK_PUSH);
    chk({o_dec_extra_reg, o_dec_reglist}, 9'h103);
    step(3, 32'h0, 3'h0);
    chk(o_pc, 32'h102);
    chk(o_instr, 32'h6fc1);
    chk({o_dec_kind, o_dec_size, o_dec_offset}, {DK_LS_IMM, SZ_WORD, 10'h07c});
    @(posedge i_sys_clk);
    i_big_endian <= 1'b1;
    step(3, 32'h0, 3'h0);
    chk(o_instr, 32'h6fc1);
    step(0, 32'h200, 3'h0);
    chk({o_state_compact, o_pc}, 33'h0_0000_0200);
    chk(o_instr, FETCH_WORD);
  endtask
  task automatic t_exc();
    step(0, 32'h101, 3'h0);
    step(1, 32'h0, EX_IRQ);
    chk({o_state_compact, o_link_we, o_link_mode}, {2'b01, MD_IRQ});
    chk(o_link_value, 32'h100);
    chk(o_pc, 32'h18);
    step(2, 32'h100, MD_IRQ);
    chk(o_state_compact, 1'b1);
    for (int k = 0; k < 8; k++) begin
      if (k == 5) continue;
      step(1, 32'h0, 3'(k));
      chk({o_state_compact, o_pc}, {28'h0, 3'(k), 2'h0});
    end
  endtask
  task automatic t_lanes();
    logic [1:0] l;
    for (int be = 0; be < 2; be++) begin
      @(posedge i_sys_clk);
      i_big_endian <= be[0];
      slow <= be[0];
      for (int a = 0; a < 4; a++) begin
        l = be[0] ? 2'(3 - a) : 2'(a);
        mem_op(1'b0, SZ_BYTE, 32'h40 + a, 32'h0, 4'h1 << l, 32'h11 * (l + 1));
      end
      mem_op(1'b0, SZ_HALF, 32'h42, 32'h0, be[0] ? 4'h3 : 4'hc, be[0] ? 32'h2211 : 32'h4433);
      mem_op(1'b0, SZ_WORD, 32'h44, 32'h0, 4'hf, 32'h4433_2211);
    end
    mem_op(1'b1, SZ_BYTE, 32'h3, 32'hab, 4'h1, 32'habab_abab);
  endtask
  // Reset for 9 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1;
    chk({o_state_compact, o_pc, o_dec_size}, {1'b0, RESET_VECTOR_BASE, SZ_WORD});
    @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    t_state();
    t_exc();
    t_lanes();
    tally_and_finish();
  end
  // Watchdog: scenarios need about a hundred cycles
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule
